//--- core/sdtx_map.vh
`ifndef SDTX_MAP_VH
`define SDTX_MAP_VH

// register port offsets
`define SDTX_ADDR_CMD 4'h0
`define SDTX_ADDR_TX_CTL 4'h1
`define SDTX_ADDR_MISC 4'h2
`define SDTX_ADDR_EXT 4'h3
`define SDTX_ADDR_ENH 4'h4
`define SDTX_ADDR_TX_BUF 4'h5
`define SDTX_ADDR_STATUS 4'h6

// command field and codes
`define SDTX_CMD_MSB 7
`define SDTX_CMD_LSB 6
`define SDTX_CMD_RST_CRC 2'h2
`define SDTX_CMD_RST_EOM 2'h3

// tx_control_reg fields
`define SDTX_CTL_CRC_EN 0
`define SDTX_CTL_TX_EN 3

// sync_tx_misc_control_reg fields
`define SDTX_MISC_ABORT_UNDERRUN 2
`define SDTX_MISC_MARK_IDLE 3
`define SDTX_MISC_NRZI 5
`define SDTX_MISC_PRESET_ONES 7

// extension_control_reg fields
`define SDTX_EXT_ENABLE 0

// tx_enhancement_options_reg fields
`define SDTX_ENH_AUTO_FLAG 0
`define SDTX_ENH_AUTO_FRAME 1
`define SDTX_ENH_FORCE_HIGH 3

// primary_status_reg fields
`define SDTX_STAT_SENDING 0
`define SDTX_STAT_BUF_EMPTY 2
`define SDTX_STAT_EOM 6

// reset values
`define SDTX_RST_TX_CTL 8'h00
`define SDTX_RST_MISC 8'h00
`define SDTX_RST_EXT 8'h00
`define SDTX_RST_ENH 8'h00

// line patterns, sent lsb first
`define SDTX_PAT_FLAG 8'h7E
`define SDTX_PAT_MARK 8'hFF
`define SDTX_PAT_ABORT 8'h7F

// crc
`define SDTX_CRC_POLY 16'h1021
`define SDTX_CRC_ONES 16'hFFFF
`define SDTX_CRC_ZEROS 16'h0000

// timing: clock cycles per line bit, stuffing run length, last bit indices
`define SDTX_BIT_DIV 8'h04
`define SDTX_STUFF_RUN 3'h5
`define SDTX_LAST_CHAR_BIT 4'h7
`define SDTX_LAST_CRC_BIT 4'hF

`endif

//--- core/sdtx_crc16.v
`timescale 1ns/1ps
`include "sdtx_map.vh"
module sdtx_crc16 (
  // clock and reset
  input wire clock_in,
  input wire rst_n_in,
  // control
  input wire preset_in,
  input wire preset_ones_in,
  input wire update_in,
  input wire bit_in,
  input wire shift_in,
  // result
  output wire msb_out
);
  reg [15:0] crc_reg;
  wire fb = crc_reg[15] ^ bit_in;

  always @(posedge clock_in) begin
    if (!rst_n_in) begin
      crc_reg <= `SDTX_CRC_ZEROS;
    end else if (preset_in) begin
      crc_reg <= preset_ones_in ? `SDTX_CRC_ONES : `SDTX_CRC_ZEROS;
    end else if (update_in) begin
      crc_reg <= {crc_reg[14:0], 1'b0} ^ (fb ? `SDTX_CRC_POLY : `SDTX_CRC_ZEROS);
    end else if (shift_in) begin
      crc_reg <= {crc_reg[14:0], 1'b0};
    end
  end

  assign msb_out = crc_reg[15];
endmodule // sdtx_crc16

//--- core/sdtx_nrzi.v
`timescale 1ns/1ps
module sdtx_nrzi (
  // clock and reset
  input wire clock_in,
  input wire rst_n_in,
  // bit stream
  input wire bit_en_in,
  input wire bit_in,
  input wire nrzi_en_in,
  // line level
  output wire level_out
);
  reg level_reg;

  // level only moves on a bit, so a stopped transmitter holds its last state
  always @(posedge clock_in) begin
    if (!rst_n_in) begin
      level_reg <= 1'b1;
    end else if (bit_en_in) begin
      if (nrzi_en_in) begin
        if (!bit_in) begin
          level_reg <= ~level_reg;
        end
      end else begin
        level_reg <= bit_in;
      end
    end
  end

  assign level_out = level_reg;
endmodule // sdtx_nrzi

//--- core/sdtx_frame_control.v
// Our own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`include "sdtx_map.vh"
// Functional notes
// (R1) extension plus auto-flag: data written during mark idle gets an opening flag first
// (R2) idle pattern leaves as whole 8-bit units; next unit loads at boundary
// (R3) without auto-flag, buffered data replaces a flag not yet loaded
// (R4) extension plus auto-frame presets transmit crc per frame to selected value
// (R5) extension plus auto-frame clears underrun latch at each frame start
// (R6) extension enabled presets transmit crc when an opening flag was sent
// (R7) without auto preset, software resets crc while idling before data
// (R8) crc runs only when crc enable is set; covers data between flags
// (R9) underrun with transmitter disabled never sends crc
// (R10) underrun latch set only by transmitter, cleared by command or by an auto-frame frame start
// (R11) underrun, enabled, latch set: close frame with flag only
// (R12) underrun, enabled, latch clear: crc or abort, then flag; with abort and crc enable both clear the code sends the flag only
// (R13) after closing flag idle with marks or flags per select bit
// (R14) software keeps abort clear and resets latch mid-frame for crc
// (R15) software should arm abort when clearing latch, drop it near end
// (R16) extension plus force-high drives serial output high under nrzi
// (R17) force-high chops current character; buffer writes while set are lost
// (R18) clearing force-high returns output to encoder state
// (R19) software sets mark idle and clears abort for force-high
// (R20) disabled transmitter leaves output at last nrzi level
// (R21) extension disabled turns off all enhanced options
module sdtx_frame_control (
  // clock and reset
  input wire clock_in,
  input wire rst_n_in,
  // register port
  input wire [3:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  output reg [7:0] reg_rdata_out,
  // serial line
  output reg txd_out,
  // status
  output reg frame_active_out,
  output reg tx_buf_empty_out
);
  localparam ST_IDLE = 6'h01;
  localparam ST_FLAG = 6'h02;
  localparam ST_DATA = 6'h04;
  localparam ST_CRC = 6'h08;
  localparam ST_ABORT = 6'h10;
  localparam ST_CLOSE = 6'h20;

  reg [7:0] tx_control_reg;
  reg [7:0] sync_tx_misc_control_reg;
  reg [7:0] extension_control_reg;
  reg [7:0] tx_enhancement_options_reg;
  reg [7:0] tx_buffer_reg;
  reg buf_full_reg;
  reg underrun_end_of_message_latch;
  reg [5:0] state_reg;
  reg [7:0] shift_reg;
  reg [3:0] bit_cnt_reg;
  reg [2:0] ones_cnt_reg;
  reg flag_unit_reg;
  reg tail_stuff_reg;
  reg force_q_reg;
  reg [7:0] div_cnt_reg;
  reg bit_tick_reg;

  reg [5:0] nxt_state;
  reg [7:0] nxt_shift;
  reg nxt_flag;
  reg frame_start;
  reg take_buf;
  reg underrun;
  reg [7:0] rd_mux;

  wire crc_msb;
  wire nrzi_level;

  // enhanced options are all gated by the extension enable [R21]
  wire ext_on = extension_control_reg[`SDTX_EXT_ENABLE];
  wire auto_flag_on = ext_on & tx_enhancement_options_reg[`SDTX_ENH_AUTO_FLAG];
  wire auto_frame_on = ext_on & tx_enhancement_options_reg[`SDTX_ENH_AUTO_FRAME];
  wire nrzi_on = sync_tx_misc_control_reg[`SDTX_MISC_NRZI];
  wire force_on = ext_on & tx_enhancement_options_reg[`SDTX_ENH_FORCE_HIGH] & nrzi_on;
  wire tx_en = tx_control_reg[`SDTX_CTL_TX_EN];
  wire crc_en = tx_control_reg[`SDTX_CTL_CRC_EN];
  wire mark_idle = sync_tx_misc_control_reg[`SDTX_MISC_MARK_IDLE];
  wire abort_on = sync_tx_misc_control_reg[`SDTX_MISC_ABORT_UNDERRUN];
  wire preset_ones = sync_tx_misc_control_reg[`SDTX_MISC_PRESET_ONES];
  wire [7:0] idle_pat = mark_idle ? `SDTX_PAT_MARK : `SDTX_PAT_FLAG;

  wire wr_cmd = reg_wr_in && (reg_addr_in == `SDTX_ADDR_CMD);
  wire [1:0] cmd_code = reg_wdata_in[`SDTX_CMD_MSB:`SDTX_CMD_LSB];
  wire cmd_rst_crc = wr_cmd && (cmd_code == `SDTX_CMD_RST_CRC);
  wire cmd_rst_eom = wr_cmd && (cmd_code == `SDTX_CMD_RST_EOM);
  wire wr_buf = reg_wr_in && (reg_addr_in == `SDTX_ADDR_TX_BUF);

  wire in_data = (state_reg == ST_DATA);
  wire in_crc = (state_reg == ST_CRC);
  wire stuffing = in_data | in_crc;
  // five ones that end a stuffed unit still owe their zero,
  // even when the next unit is a flag or abort that is never stuffed
  wire stuff_now = (stuffing & (ones_cnt_reg == `SDTX_STUFF_RUN)) | tail_stuff_reg;
  // a disabled transmitter stops as soon as it is idle, even in the middle of an idle unit [R20]
  // a zero still owed is sent first so the closing pattern stays clean
  wire run = tx_en | (state_reg != ST_IDLE) | tail_stuff_reg;
  wire tick = bit_tick_reg & run;
  wire chop = force_on & ~force_q_reg;
  wire cur_bit = stuff_now ? 1'b0 : (in_crc ? ~crc_msb : shift_reg[0]);
  wire [3:0] last_cnt = in_crc ? `SDTX_LAST_CRC_BIT : `SDTX_LAST_CHAR_BIT;
  wire last_bit = ~stuff_now & (bit_cnt_reg == last_cnt);
  wire boundary = tick & last_bit & ~chop;
  wire nxt_stuffing = (nxt_state == ST_DATA) | (nxt_state == ST_CRC);
  // fifth one lands on the last bit and the next unit is not stuffed
  wire tail_stuff_set = stuffing & cur_bit & ~nxt_stuffing
    & (ones_cnt_reg == (`SDTX_STUFF_RUN - 3'h1));

  // with the extension on, preset when a frame opens behind a flag, or every frame with auto-frame
  wire auto_preset = ext_on & flag_unit_reg; // [R6]
  wire frame_preset = boundary & frame_start & (auto_preset | auto_frame_on); // [R4]
  wire crc_preset = cmd_rst_crc | frame_preset;
  wire crc_update = tick & ~chop & in_data & ~stuff_now & crc_en; // [R8]
  wire crc_shift = tick & ~chop & in_crc & ~stuff_now;
  wire latch_set = boundary & underrun;
  wire latch_clr = cmd_rst_eom | (boundary & frame_start & auto_frame_on); // [R5]

  // bit rate divider
  always @(posedge clock_in) begin
    if (!rst_n_in) begin
      div_cnt_reg <= 8'h00;
      bit_tick_reg <= 1'b0;
    end else if (div_cnt_reg == (`SDTX_BIT_DIV - 8'h01)) begin
      div_cnt_reg <= 8'h00;
      bit_tick_reg <= 1'b1;
    end else begin
      div_cnt_reg <= div_cnt_reg + 8'h01;
      bit_tick_reg <= 1'b0;
    end
  end

  // choice of the next unit (8 bits, or 16 for crc) at a unit boundary
  always @* begin
    nxt_state = ST_IDLE;
    nxt_shift = idle_pat; // [R13]
    nxt_flag = ~mark_idle;
    frame_start = 1'b0;
    take_buf = 1'b0;
    underrun = 1'b0;
    if (in_data) begin
      if (buf_full_reg & tx_en) begin
        nxt_state = ST_DATA;
        nxt_shift = tx_buffer_reg;
        nxt_flag = 1'b0;
        take_buf = 1'b1;
      end else begin
        underrun = 1'b1;
        if (!tx_en) begin
          nxt_state = ST_IDLE; // [R9]
        end else if (underrun_end_of_message_latch | (~abort_on & ~crc_en)) begin
          nxt_state = ST_CLOSE; // [R11]
          nxt_shift = `SDTX_PAT_FLAG;
          nxt_flag = 1'b1;
        end else if (abort_on) begin
          nxt_state = ST_ABORT; // [R12]
          nxt_shift = `SDTX_PAT_ABORT;
          nxt_flag = 1'b0;
        end else begin
          nxt_state = ST_CRC; // [R12]
          nxt_flag = 1'b0;
        end
      end
    end else if (in_crc | (state_reg == ST_ABORT)) begin
      nxt_state = ST_CLOSE; // [R12]
      nxt_shift = `SDTX_PAT_FLAG;
      nxt_flag = 1'b1;
    end else if (buf_full_reg & tx_en) begin
      if (mark_idle & auto_flag_on & ~flag_unit_reg) begin
        nxt_state = ST_FLAG; // [R1]
        nxt_shift = `SDTX_PAT_FLAG;
        nxt_flag = 1'b1;
      end else begin
        // flag idle, no auto-flag, or a flag just sent: data simply takes the next unit's place [R3]
        nxt_state = ST_DATA;
        nxt_shift = tx_buffer_reg;
        nxt_flag = 1'b0;
        take_buf = 1'b1;
        frame_start = 1'b1;
      end
    end
  end

  // bit sequencer
  always @(posedge clock_in) begin
    if (!rst_n_in) begin
      state_reg <= ST_IDLE;
      shift_reg <= `SDTX_PAT_FLAG;
      bit_cnt_reg <= 4'h0;
      ones_cnt_reg <= 3'h0;
      flag_unit_reg <= 1'b0;
      tail_stuff_reg <= 1'b0;
    end else if (chop) begin
      // whatever was in flight is dropped, line restarts on idle [R17]
      state_reg <= ST_IDLE;
      shift_reg <= idle_pat;
      bit_cnt_reg <= 4'h0;
      ones_cnt_reg <= 3'h0;
      flag_unit_reg <= ~mark_idle;
      tail_stuff_reg <= 1'b0;
    end else if (tick) begin
      if (stuff_now) begin
        ones_cnt_reg <= 3'h0;
        tail_stuff_reg <= 1'b0;
      end else if (last_bit) begin
        // units are split only by a chop: otherwise a new pattern loads only here [R2]
        state_reg <= nxt_state;
        shift_reg <= nxt_shift;
        bit_cnt_reg <= 4'h0;
        flag_unit_reg <= nxt_flag;
        tail_stuff_reg <= tail_stuff_set;
        if (stuffing & cur_bit & nxt_stuffing) begin
          ones_cnt_reg <= ones_cnt_reg + 3'h1;
        end else begin
          ones_cnt_reg <= 3'h0;
        end
      end else begin
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
        shift_reg <= {1'b1, shift_reg[7:1]};
        if (stuffing & cur_bit) begin
          ones_cnt_reg <= ones_cnt_reg + 3'h1;
        end else begin
          ones_cnt_reg <= 3'h0;
        end
      end
    end
  end

  // control registers
  always @(posedge clock_in) begin
    if (!rst_n_in) begin
      tx_control_reg <= `SDTX_RST_TX_CTL;
      sync_tx_misc_control_reg <= `SDTX_RST_MISC;
      extension_control_reg <= `SDTX_RST_EXT;
      tx_enhancement_options_reg <= `SDTX_RST_ENH;
    end else if (reg_wr_in) begin
      if (reg_addr_in == `SDTX_ADDR_TX_CTL) begin
        tx_control_reg <= reg_wdata_in;
      end else if (reg_addr_in == `SDTX_ADDR_MISC) begin
        // abort-on-underrun stays freely writable [R10]
        sync_tx_misc_control_reg <= reg_wdata_in;
      end else if (reg_addr_in == `SDTX_ADDR_EXT) begin
        extension_control_reg <= reg_wdata_in;
      end else if (reg_addr_in == `SDTX_ADDR_ENH) begin
        tx_enhancement_options_reg <= reg_wdata_in;
      end
    end
  end

  // transmit buffer; a write beside a load wins so no character is lost
  always @(posedge clock_in) begin
    if (!rst_n_in) begin
      tx_buffer_reg <= 8'h00;
      buf_full_reg <= 1'b0;
    end else if (wr_buf & ~force_on) begin
      tx_buffer_reg <= reg_wdata_in;
      buf_full_reg <= 1'b1;
    end else if (boundary & take_buf) begin
      buf_full_reg <= 1'b0;
    end
  end

  // underrun latch: set wins over a clear in the same cycle
  always @(posedge clock_in) begin
    if (!rst_n_in) begin
      underrun_end_of_message_latch <= 1'b0;
    end else if (latch_set) begin
      underrun_end_of_message_latch <= 1'b1; // [R10]
    end else if (latch_clr) begin
      underrun_end_of_message_latch <= 1'b0; // [R10]
    end
  end

  sdtx_crc16 u_crc (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .preset_in(crc_preset),
    .preset_ones_in(preset_ones),
    .update_in(crc_update),
    .bit_in(cur_bit),
    .shift_in(crc_shift),
    .msb_out(crc_msb)
  );

  sdtx_nrzi u_nrzi (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .bit_en_in(tick & ~chop),
    .bit_in(cur_bit),
    .nrzi_en_in(nrzi_on),
    .level_out(nrzi_level)
  );

  // forcing only masks the pin; the encoder keeps its own state [R18]
  always @(posedge clock_in) begin
    if (!rst_n_in) begin
      txd_out <= 1'b1;
      force_q_reg <= 1'b0;
      frame_active_out <= 1'b0;
      tx_buf_empty_out <= 1'b1;
    end else begin
      txd_out <= force_on ? 1'b1 : nrzi_level; // [R16]
      force_q_reg <= force_on;
      frame_active_out <= (state_reg != ST_IDLE);
      tx_buf_empty_out <= ~buf_full_reg;
    end
  end

  // read mux
  always @* begin
    rd_mux = 8'h00;
    if (reg_addr_in == `SDTX_ADDR_TX_CTL) begin
      rd_mux = tx_control_reg;
    end else if (reg_addr_in == `SDTX_ADDR_MISC) begin
      rd_mux = sync_tx_misc_control_reg;
    end else if (reg_addr_in == `SDTX_ADDR_EXT) begin
      rd_mux = extension_control_reg;
    end else if (reg_addr_in == `SDTX_ADDR_ENH) begin
      rd_mux = tx_enhancement_options_reg;
    end else if (reg_addr_in == `SDTX_ADDR_STATUS) begin
      rd_mux[`SDTX_STAT_SENDING] = (state_reg != ST_IDLE);
      rd_mux[`SDTX_STAT_BUF_EMPTY] = ~buf_full_reg;
      rd_mux[`SDTX_STAT_EOM] = underrun_end_of_message_latch;
    end
  end

  // read data stands only in the cycle after the strobe
  always @(posedge clock_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      reg_rdata_out <= rd_mux;
    end else begin
      reg_rdata_out <= 8'h00;
    end
  end
endmodule // sdtx_frame_control

//--- tb/sdtx_frame_control_chk.sv
`timescale 1ns/1ps
`include "sdtx_map.vh"
module sdtx_frame_control_chk (
  // clock and reset
  input wire clock_in,
  input wire rst_n_in,
  // register port
  input wire [3:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  input wire [7:0] reg_rdata_out,
  // line and status
  input wire txd_out,
  input wire frame_active_out,
  input wire tx_buf_empty_out
);
  reg ext_reg;
  reg high_reg;
  reg nrzi_reg;
  reg tx_en_reg;
  reg [2:0] high_cnt_reg;
  reg [3:0] quiet_cnt_reg;
  wire force_on = ext_reg & high_reg & nrzi_reg;
  wire buf_wr = reg_wr_in && reg_addr_in == `SDTX_ADDR_TX_BUF;
  // shadows land on the same edge as the design's own registers
  always @(posedge clock_in) begin
    if (!rst_n_in) begin
      ext_reg <= 1'b0;
      high_reg <= 1'b0;
      nrzi_reg <= 1'b0;
      tx_en_reg <= 1'b0;
    end else if (reg_wr_in) begin
      if (reg_addr_in == `SDTX_ADDR_EXT) ext_reg <= reg_wdata_in[`SDTX_EXT_ENABLE];
      if (reg_addr_in == `SDTX_ADDR_ENH) high_reg <= reg_wdata_in[`SDTX_ENH_FORCE_HIGH];
      if (reg_addr_in == `SDTX_ADDR_MISC) nrzi_reg <= reg_wdata_in[`SDTX_MISC_NRZI];
      if (reg_addr_in == `SDTX_ADDR_TX_CTL) tx_en_reg <= reg_wdata_in[`SDTX_CTL_TX_EN];
    end
  end
  always @(posedge clock_in) begin
    if (!rst_n_in || !force_on) high_cnt_reg <= 3'h0;
    else if (high_cnt_reg != 3'h7) high_cnt_reg <= high_cnt_reg + 3'h1;
  end
  // output lag must drain before the line counts as quiet
  always @(posedge clock_in) begin
    if (!rst_n_in || force_on || tx_en_reg || frame_active_out) quiet_cnt_reg <= 4'h0;
    else if (quiet_cnt_reg != 4'hF) quiet_cnt_reg <= quiet_cnt_reg + 4'h1;
  end
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_eom_cmd;
    buf_wr == 1'b0 && reg_wr_in && reg_addr_in == `SDTX_ADDR_CMD && !frame_active_out
      && reg_wdata_in[`SDTX_CMD_MSB:`SDTX_CMD_LSB] == `SDTX_CMD_RST_EOM;
  endsequence
  sequence s_stat_rd;
    reg_rd_in && reg_addr_in == `SDTX_ADDR_STATUS;
  endsequence
  property p_eom_clear;
    s_eom_cmd ##[1:2] s_stat_rd |=> !reg_rdata_out[`SDTX_STAT_EOM];
  endproperty
  a_eom_clear: assert property (p_eom_clear)
    else $error("underrun latch still set after clear command");
  property p_rd_quiet;
    !$past(reg_rd_in) |-> reg_rdata_out == 8'h00;
  endproperty
  a_rd_quiet: assert property (p_rd_quiet)
    else $error("read data outside its cycle");
  property p_rd_unmapped;
    reg_rd_in && reg_addr_in > `SDTX_ADDR_STATUS |=> reg_rdata_out == 8'h00;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped)
    else $error("unmapped read not zero");
  property p_force_high;
    high_cnt_reg > 3'h3 |-> txd_out;
  endproperty
  a_force_high: assert property (p_force_high)
    else $error("line not forced high");
  property p_discard;
    force_on && buf_wr && tx_buf_empty_out |=> tx_buf_empty_out [*3];
  endproperty
  a_discard: assert property (p_discard)
    else $error("buffer write kept while forced high");
  property p_chop;
    $rose(force_on) |-> ##[1:4] !frame_active_out;
  endproperty
  a_chop: assert property (p_chop)
    else $error("frame not cut off by force high");
  property p_accept;
    buf_wr && !force_on && tx_en_reg && tx_buf_empty_out |-> ##[1:3] !tx_buf_empty_out;
  endproperty
  a_accept: assert property (p_accept)
    else $error("buffer write lost without force high");
  property p_hold;
    quiet_cnt_reg > 4'h7 |-> $stable(txd_out);
  endproperty
  a_hold: assert property (p_hold)
    else $error("disabled line changed level");
endmodule // sdtx_frame_control_chk

//--- tb/sdtx_line_station.sv
`timescale 1ns/1ps
module sdtx_line_station (
  // clock and reset
  input wire clock_in,
  input wire rst_n_in,
  // serial line
  input wire line_in,
  input wire nrzi_in
);
  bit bits[$];
  reg [1:0] phase_reg;
  reg last_reg;
  // sample once per bit, three clocks after the sender's edge and one before its next
  always @(posedge clock_in) begin
    if (!rst_n_in) begin
      phase_reg <= 2'h0;
      last_reg <= 1'b1;
    end else begin
      phase_reg <= phase_reg + 2'h1;
      if (phase_reg == 2'h0) begin
        bits.push_back(nrzi_in ? line_in == last_reg : line_in);
        last_reg <= line_in;
      end
    end
  end
endmodule // sdtx_line_station

//--- tb/sdtx_frame_control_test.sv
`timescale 1ns/1ps
`include "sdtx_map.vh"
module sdtx_frame_control_test;
  logic clock_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [3:0] reg_addr_in = 4'h0;
  logic [7:0] reg_wdata_in = 8'h00;
  logic reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0;
  logic peer_nrzi = 1'b0;
  wire [7:0] reg_rdata_out;
  wire txd_out;
  wire frame_active_out;
  wire tx_buf_empty_out;
  logic [31:0] lfsr = 32'h00016286;
  logic [7:0] s;
  bit exp_q[$];
  int run;
  int a;
  int n_fail = 0;
  int comparisons = 0;
  always #5 clock_in = ~clock_in;
  sdtx_frame_control u_dut (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out),
    .txd_out(txd_out),
    .frame_active_out(frame_active_out),
    .tx_buf_empty_out(tx_buf_empty_out)
  );
  sdtx_line_station u_peer (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .line_in(txd_out),
    .nrzi_in(peer_nrzi)
  );
  function automatic [7:0] rnd();
    int i;
    for (i = 0; i < 8; i++) lfsr = {1'b0, lfsr[31:1]} ^ (lfsr[0] ? 32'hA3000000 : 32'h0);
    return lfsr[7:0];
  endfunction
  task check(input logic [15:0] seen, input logic [15:0] exp);
    begin
      comparisons++;
      if (seen !== exp) begin
        n_fail++;
        $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task summarize;
    begin
      if (n_fail == 0 && comparisons > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  task wr(input [3:0] ad, input [7:0] d);
    begin
      @(posedge clock_in);
      reg_addr_in <= ad;
      reg_wdata_in <= d;
      reg_wr_in <= 1'b1;
      @(posedge clock_in);
      reg_wr_in <= 1'b0;
    end
  endtask
  task rd(input [3:0] ad, output logic [7:0] d);
    begin
      @(posedge clock_in);
      reg_addr_in <= ad;
      reg_rd_in <= 1'b1;
      @(posedge clock_in);
      reg_rd_in <= 1'b0;
      #1 d = reg_rdata_out;
    end
  endtask
  task stat(input [7:0] e);
    begin
      rd(`SDTX_ADDR_STATUS, s);
      check(s & 8'h44, e);
    end
  endtask
  task wait_on(input bit sel, input logic v);
    int n;
    begin
      n = 0;
      #1;
      while ((sel ? tx_buf_empty_out : frame_active_out) !== v && n < 3000) begin
        @(posedge clock_in);
        #1;
        n++;
      end
      check(sel ? tx_buf_empty_out : frame_active_out, v);
    end
  endtask
  task put(input [7:0] v, input bit stuff);
    int i;
    begin
      for (i = 0; i < 8; i++) begin
        exp_q.push_back(v[i]);
        run = (stuff && v[i]) ? run + 1 : 0;
        if (run == 5) exp_q.push_back(1'b0);
        if (run == 5) run = 0;
      end
    end
  endtask
  // tail: 0 crc, 1 abort, 2 flag only
  task frame(input [7:0] head, input bit opn, input bit clr, input [1:0] tail,
             input [15:0] seed, input [7:0] idle);
    logic [7:0] b0;
    logic [7:0] b1;
    logic [15:0] crc;
    logic [7:0] c8;
    int i;
    int j;
    int hit;
    begin
      b0 = rnd();
      b1 = rnd();
      crc = seed;
      exp_q.delete();
      put(head, 0);
      if (opn) put(`SDTX_PAT_FLAG, 0);
      run = 0;
      put(b0, 1);
      put(b1, 1);
      for (i = 0; i < 16; i++) begin
        j = (i < 8) ? b0[i] : b1[i - 8];
        crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ j[0]) ? `SDTX_CRC_POLY : 16'h0000);
      end
      for (i = 0; i < 8; i++) c8[i] = ~crc[15 - i];
      if (tail == 0) put(c8, 1);
      for (i = 0; i < 8; i++) c8[i] = ~crc[7 - i];
      if (tail == 0) put(c8, 1);
      if (tail == 1) put(`SDTX_PAT_ABORT, 0);
      put(`SDTX_PAT_FLAG, 0);
      put(idle, 0);
      u_peer.bits.delete();
      repeat (40) @(posedge clock_in);
      wr(`SDTX_ADDR_TX_BUF, b0);
      repeat (3) @(posedge clock_in);
      wait_on(1, 1'b1);
      if (clr) wr(`SDTX_ADDR_CMD, {`SDTX_CMD_RST_EOM, 6'h00});
      wr(`SDTX_ADDR_TX_BUF, b1);
      repeat (3) @(posedge clock_in);
      wait_on(0, 1'b0);
      repeat (96) @(posedge clock_in);
      hit = 0;
      for (i = 0; i + exp_q.size() <= u_peer.bits.size() && hit == 0; i++) begin
        hit = 1;
        for (j = 0; j < exp_q.size(); j++) if (u_peer.bits[i + j] !== exp_q[j]) hit = 0;
      end
      check(hit, 1);
    end
  endtask
  initial begin
    repeat (40000) @(posedge clock_in);
    n_fail++;
    summarize;
  end
  initial begin
    repeat (2) @(posedge clock_in);
    rst_n_in <= 1'b1;
    stat(8'h04);
    @(posedge clock_in);
    #1 check(reg_rdata_out, 8'h00);
    for (a = 5; a < 16; a++) begin
      rd(a[3:0], s);
      if (a != 6) check(s, 8'h00);
    end
    wr(`SDTX_ADDR_TX_CTL, 8'h09);
    wr(`SDTX_ADDR_CMD, {`SDTX_CMD_RST_CRC, 6'h00});
    frame(8'h7E, 0, 1, 0, 16'h0000, 8'h7E);
    stat(8'h44);
    frame(8'h7E, 0, 0, 2, 16'h0000, 8'h7E);
    wr(`SDTX_ADDR_CMD, {`SDTX_CMD_RST_EOM, 6'h00});
    stat(8'h04);
    wr(`SDTX_ADDR_MISC, 8'h04);
    stat(8'h04);
    frame(8'h7E, 0, 1, 1, 16'h0000, 8'h7E);
    wr(`SDTX_ADDR_MISC, 8'hA0);
    peer_nrzi <= 1'b1;
    wr(`SDTX_ADDR_EXT, 8'h01);
    wr(`SDTX_ADDR_ENH, 8'h02);
    frame(8'h7E, 0, 0, 0, 16'hFFFF, 8'h7E);
    peer_nrzi <= 1'b0;
    // preset to ones: a missed flag preset would leave the drained zero crc
    wr(`SDTX_ADDR_MISC, 8'h88);
    wr(`SDTX_ADDR_ENH, 8'h01);
    frame(8'hFF, 1, 1, 0, 16'hFFFF, 8'hFF);
    wr(`SDTX_ADDR_EXT, 8'h00);
    wr(`SDTX_ADDR_CMD, {`SDTX_CMD_RST_CRC, 6'h00});
    frame(8'hFF, 0, 1, 0, 16'hFFFF, 8'hFF);
    wr(`SDTX_ADDR_EXT, 8'h01);
    wr(`SDTX_ADDR_MISC, 8'h28);
    wr(`SDTX_ADDR_ENH, 8'h08);
    for (a = 0; a < 4; a++) begin
      repeat (9) @(posedge clock_in);
      #1 check(txd_out, 1'b1);
    end
    wr(`SDTX_ADDR_TX_BUF, rnd());
    repeat (4) @(posedge clock_in);
    #1 check({frame_active_out, tx_buf_empty_out}, 2'h1);
    wr(`SDTX_ADDR_ENH, 8'h00);
    wr(`SDTX_ADDR_MISC, 8'h20);
    wr(`SDTX_ADDR_TX_BUF, rnd());
    wait_on(0, 1'b1);
    wr(`SDTX_ADDR_ENH, 8'h08);
    repeat (6) @(posedge clock_in);
    #1 check(frame_active_out, 1'b0);
    wr(`SDTX_ADDR_EXT, 8'h00);
    wait_on(1, 1'b1);
    wait_on(0, 1'b0);
    wr(`SDTX_ADDR_CMD, {`SDTX_CMD_RST_EOM, 6'h00});
    wr(`SDTX_ADDR_TX_BUF, rnd());
    wait_on(0, 1'b1);
    // latch clear: a crc tail and its closing flag would keep the frame up for 96 more cycles
    wr(`SDTX_ADDR_TX_CTL, 8'h01);
    repeat (40) @(posedge clock_in);
    #1 check(frame_active_out, 1'b0);
    wait_on(0, 1'b0);
    stat(8'h44);
    repeat (200) @(posedge clock_in);
    summarize;
  end
endmodule // sdtx_frame_control_test
bind sdtx_frame_control sdtx_frame_control_chk u_chk (
  .clock_in(clock_in),
  .rst_n_in(rst_n_in),
  .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in),
  .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out),
  .txd_out(txd_out),
  .frame_active_out(frame_active_out),
  .tx_buf_empty_out(tx_buf_empty_out)
);
